// file: src/lpmc_top.sv
`timescale 1ns/1ps
module lpmc_top (
   input wire logic clk_i,                // 25 MHz system clock
   input wire logic rst_i,                // synchronous reset, active high
   input wire logic [7:0] wb_adr_i,       // byte address
   input wire logic [31:0] wb_dat_i,      // write data
   output logic [31:0] wb_dat_o,          // read data
   input wire logic [3:0] wb_sel_i,       // byte enables
   input wire logic wb_we_i,              // write
   input wire logic wb_cyc_i,             // cycle
   input wire logic wb_stb_i,             // strobe
   output logic wb_ack_o,                 // acknowledge
   output logic wb_err_o,                 // unmapped address
   input wire logic wfi_i,                // wait instruction pulse from core
   input wire logic any_irq_i,            // any interrupt pending
   input wire logic wake_irq_i,           // wake-source interrupt pending
   input wire logic snooze_req_i,         // snooze request trigger
   input wire logic reset_cancel_i,       // reset usable in current mode
   output logic [2:0] mode_o,             // current low-power mode
   output logic resume_o,                 // pulse: resume via interrupt
   output logic reset_req_o,              // pulse: go to reset state
   output logic [1:0] opc_mode_o,         // operating power mode
   output logic [6:0] osc_allow_o,        // oscillators allowed
   output logic [31:0] clk_div_o,         // per-clock divider settings
   output logic bus_clk_high_o,           // bus clock pin forced high
   output logic [31:0] module_stop_o,     // 1 = module stopped
   output logic [31:0] secure_attr_o      // security attribute per register
);

   ////////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      lpmc_pkg::lpmc_mode_t mode;
      lpmc_pkg::lpmc_exit_t exits;
      logic standby_sel;
      logic deep_sel;
      logic snooze_en;
      lpmc_pkg::lpmc_opc_t opc;
      logic [6:0] osc;
      logic [31:0] clk_div;
      logic bus_clk_high;
      logic [31:0] mstop;
      logic [31:0] secure;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } lpmc_state_t;

   lpmc_state_t state_reg;
   lpmc_state_t state_next;

   ////////////////////////////////////////////////////////////////////////
   // byte-lane merge, used by every writable register
   function automatic logic [31:0] lpmc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // oscillator permission for a power mode
   function automatic logic [6:0] lpmc_osc(input lpmc_pkg::lpmc_opc_t m);
      case (m)
         lpmc_pkg::LPMC_OPC_HIGH: lpmc_osc = lpmc_pkg::OSC_ALL;
         lpmc_pkg::LPMC_OPC_LOW: lpmc_osc = lpmc_pkg::OSC_NO_PLL;
         lpmc_pkg::LPMC_OPC_SUBOSC: lpmc_osc = lpmc_pkg::OSC_SUBOSC;
         default: lpmc_osc = lpmc_pkg::OSC_ALL;
      endcase
   endfunction

   logic req;
   logic wr;
   logic [31:0] wv;
   logic [31:0] rd;
   logic hit;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic: bus slave, registers, mode sequencer
   always_comb begin
      state_next = state_reg;
      state_next.exits = '0;
      // one ack per request; drop in the cycle after it was given
      req = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
      wr = req && wb_we_i;
      wv = 32'h0000_0000;
      rd = 32'h0000_0000;
      hit = 1'b1;
      case (wb_adr_i)
         lpmc_pkg::STANDBY_CONTROL_OFS: begin
            rd[lpmc_pkg::STANDBY_SELECT_POS] = state_reg.standby_sel;
            wv = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            if (wr) begin
               state_next.standby_sel = wv[lpmc_pkg::STANDBY_SELECT_POS];
            end
         end
         lpmc_pkg::DEEP_STANDBY_CONTROL_OFS: begin
            rd[lpmc_pkg::DEEP_STANDBY_SELECT_POS] = state_reg.deep_sel;
            wv = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            if (wr) begin
               state_next.deep_sel = wv[lpmc_pkg::DEEP_STANDBY_SELECT_POS];
            end
         end
         lpmc_pkg::SNOOZE_CONTROL_OFS: begin
            rd[lpmc_pkg::SNOOZE_ENABLE_POS] = state_reg.snooze_en;
            wv = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            if (wr) begin
               state_next.snooze_en = wv[lpmc_pkg::SNOOZE_ENABLE_POS];
            end
         end
         lpmc_pkg::OPERATING_POWER_CONTROL_OFS: begin
            rd[1:0] = state_reg.opc;
            wv = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            // the unused code 2'b10 is refused; mode stays as it was
            if (wr && wv[1:0] != 2'b10) begin
               state_next.opc = lpmc_pkg::lpmc_opc_t'(wv[1:0]);
            end
         end
         lpmc_pkg::CLOCK_DIVIDER_OFS: begin
            rd = state_reg.clk_div;
            if (wr) begin
               state_next.clk_div = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            end
         end
         lpmc_pkg::BUS_CLOCK_PIN_OFS: begin
            rd[lpmc_pkg::BUS_CLOCK_HIGH_POS] = state_reg.bus_clk_high;
            wv = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            if (wr) begin
               state_next.bus_clk_high = wv[lpmc_pkg::BUS_CLOCK_HIGH_POS];
            end
         end
         lpmc_pkg::MODULE_STOP_OFS: begin
            rd = state_reg.mstop;
            if (wr) begin
               // 0 releases, 1 stops, bit by bit
               state_next.mstop = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            end
         end
         lpmc_pkg::SECURITY_ATTR_OFS: begin
            rd = state_reg.secure;
            if (wr) begin
               state_next.secure = lpmc_merge(rd, wb_dat_i, wb_sel_i);
            end
         end
         lpmc_pkg::MODE_STATUS_OFS: begin
            rd[2:0] = state_reg.mode;
            rd[10:4] = state_reg.osc;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      state_next.ack = req && hit;
      state_next.err = req && !hit;
      state_next.rdata = (req && hit && !wb_we_i) ? rd : 32'h0000_0000;

      // oscillator limits follow the register with one cycle of latency
      state_next.osc = lpmc_osc(state_reg.opc);

      // mode sequencer; a reset cancel outranks an interrupt
      case (state_reg.mode)
         lpmc_pkg::LPMC_NORMAL: begin
            if (wfi_i) begin
               if (!state_reg.standby_sel) begin
                  state_next.mode = lpmc_pkg::LPMC_SLEEP;
               end else if (!state_reg.deep_sel) begin
                  state_next.mode = lpmc_pkg::LPMC_STANDBY;
               end else begin
                  state_next.mode = lpmc_pkg::LPMC_DEEP;
               end
            end
         end
         lpmc_pkg::LPMC_SLEEP: begin
            if (reset_cancel_i) begin
               state_next.mode = lpmc_pkg::LPMC_NORMAL;
               state_next.exits.to_reset = 1'b1;
            end else if (any_irq_i || wake_irq_i) begin
               state_next.mode = lpmc_pkg::LPMC_NORMAL;
               state_next.exits.resume = 1'b1;
            end
         end
         lpmc_pkg::LPMC_STANDBY, lpmc_pkg::LPMC_SNOOZE: begin
            if (reset_cancel_i) begin
               state_next.mode = lpmc_pkg::LPMC_NORMAL;
               state_next.exits.to_reset = 1'b1;
            end else if (wake_irq_i) begin
               state_next.mode = lpmc_pkg::LPMC_NORMAL;
               state_next.exits.resume = 1'b1;
            end else if (state_reg.mode == lpmc_pkg::LPMC_STANDBY &&
                         snooze_req_i && state_reg.snooze_en) begin
               state_next.mode = lpmc_pkg::LPMC_SNOOZE;
            end
         end
         lpmc_pkg::LPMC_DEEP: begin
            // both exits of deep standby end in the reset state
            if (reset_cancel_i || wake_irq_i) begin
               state_next.mode = lpmc_pkg::LPMC_NORMAL;
               state_next.exits.to_reset = 1'b1;
            end
         end
         default: begin
            state_next.mode = lpmc_pkg::LPMC_NORMAL;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg.mode <= lpmc_pkg::LPMC_NORMAL;
         state_reg.exits <= '0;
         state_reg.standby_sel <= 1'b0;
         state_reg.deep_sel <= 1'b0;
         state_reg.snooze_en <= 1'b0;
         state_reg.opc <= lpmc_pkg::LPMC_OPC_HIGH;
         state_reg.osc <= lpmc_pkg::OSC_ALL;
         state_reg.clk_div <= lpmc_pkg::CLOCK_DIVIDER_RST;
         state_reg.bus_clk_high <= 1'b0;
         state_reg.mstop <= lpmc_pkg::MODULE_STOP_RST;
         state_reg.secure <= lpmc_pkg::SECURITY_ATTR_RST;
         state_reg.ack <= 1'b0;
         state_reg.err <= 1'b0;
         state_reg.rdata <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign wb_dat_o = state_reg.rdata;
   assign wb_ack_o = state_reg.ack;
   assign wb_err_o = state_reg.err;
   assign mode_o = state_reg.mode;
   assign resume_o = state_reg.exits.resume;
   assign reset_req_o = state_reg.exits.to_reset;
   assign opc_mode_o = state_reg.opc;
   assign osc_allow_o = state_reg.osc;
   assign clk_div_o = state_reg.clk_div;
   assign bus_clk_high_o = state_reg.bus_clk_high;
   assign module_stop_o = state_reg.mstop; // peripherals gate access
   assign secure_attr_o = state_reg.secure;

endmodule

// file: src/lpmc_pkg.sv
package lpmc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets on the wishbone slave
   localparam logic [7:0] STANDBY_CONTROL_OFS = 8'h00;
   localparam logic [7:0] DEEP_STANDBY_CONTROL_OFS = 8'h04;
   localparam logic [7:0] SNOOZE_CONTROL_OFS = 8'h08;
   localparam logic [7:0] OPERATING_POWER_CONTROL_OFS = 8'h0C;
   localparam logic [7:0] CLOCK_DIVIDER_OFS = 8'h10;
   localparam logic [7:0] BUS_CLOCK_PIN_OFS = 8'h14;
   localparam logic [7:0] MODULE_STOP_OFS = 8'h18;
   localparam logic [7:0] SECURITY_ATTR_OFS = 8'h1C;
   localparam logic [7:0] MODE_STATUS_OFS = 8'h20;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int STANDBY_SELECT_POS = 15;
   localparam int DEEP_STANDBY_SELECT_POS = 7;
   localparam int SNOOZE_ENABLE_POS = 7;
   localparam int BUS_CLOCK_HIGH_POS = 0;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   // divider field per clock: [2:0] core, [6:4] periph high, [10:8] periph
   // low, [14:12] converter, [18:16] timer, [22:20] bus, [26:24] flash
   localparam logic [31:0] CLOCK_DIVIDER_RST = 32'h0000_0000;
   // every module stopped except dma, data transfer and sram (bits 0..2)
   localparam logic [31:0] MODULE_STOP_RST = 32'hFFFF_FFF8;
   localparam logic [31:0] SECURITY_ATTR_RST = 32'h0000_0000;
   localparam logic [1:0] OPERATING_POWER_RST = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // operating power control modes
   typedef enum logic [1:0] {
      LPMC_OPC_HIGH = 2'b00,
      LPMC_OPC_LOW = 2'b01,
      LPMC_OPC_SUBOSC = 2'b11
   } lpmc_opc_t;

   // oscillator permission mask, bit 0 upward: pll, hoco, moco, loco,
   // main, sub, wdt
   localparam logic [6:0] OSC_ALL = 7'h7F;
   localparam logic [6:0] OSC_NO_PLL = 7'h7E;
   localparam logic [6:0] OSC_SUBOSC = 7'h68;

   // low-power state machine
   typedef enum logic [2:0] {
      LPMC_NORMAL = 3'b000,
      LPMC_SLEEP = 3'b001,
      LPMC_STANDBY = 3'b010,
      LPMC_SNOOZE = 3'b011,
      LPMC_DEEP = 3'b100
   } lpmc_mode_t;

   // outcome pulses toward the core
   typedef struct packed {
      logic resume;   // back to execution by interrupt processing
      logic to_reset; // request the reset state
   } lpmc_exit_t;

endpackage

// file: bench/lpmc_chk.sv
`timescale 1ns/1ps
module lpmc_chk (
   input wire logic clk_i,           // clock
   input wire logic rst_i,           // reset
   input wire logic [7:0] wb_adr_i,  // addr
   input wire logic [31:0] wb_dat_i, // wdata
   input wire logic wb_we_i,         // write
   input wire logic wb_cyc_i,        // cycle
   input wire logic wb_stb_i,        // strobe
   input wire logic wb_ack_o,        // ack
   input wire logic wb_err_o,        // error
   input wire logic wfi_i,           // wait
   input wire logic any_irq_i,       // irq
   input wire logic wake_irq_i,      // wake
   input wire logic snooze_req_i,    // snooze
   input wire logic reset_cancel_i,  // reset
   input wire logic [2:0] mode_o,    // mode
   input wire logic resume_o,        // resume
   input wire logic reset_req_o,     // to reset
   input wire logic [1:0] opc_mode_o, // opc
   input wire logic [6:0] osc_allow_o // osc
);
   logic sby_reg;
   logic dps_reg;
   logic wr_ok;
   ////////////////////////////////////////////////////////////////////
   // shadow select bits; taken at ack since the master still holds data
   assign wr_ok = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sby_reg <= 1'b0;
         dps_reg <= 1'b0;
      end else if (wr_ok && wb_adr_i == lpmc_pkg::STANDBY_CONTROL_OFS) begin
         sby_reg <= wb_dat_i[lpmc_pkg::STANDBY_SELECT_POS];
      end else if (wr_ok &&
                   wb_adr_i == lpmc_pkg::DEEP_STANDBY_CONTROL_OFS) begin
         dps_reg <= wb_dat_i[lpmc_pkg::DEEP_STANDBY_SELECT_POS];
      end
   end
   // mask expected one cycle after an operating power code
   function automatic logic [6:0] osc_of(input logic [1:0] m);
      case (m)
         2'b01: osc_of = lpmc_pkg::OSC_NO_PLL;
         2'b11: osc_of = lpmc_pkg::OSC_SUBOSC;
         default: osc_of = lpmc_pkg::OSC_ALL;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wfi_go;
      mode_o == 3'd0 && wfi_i && !reset_cancel_i;
   endsequence
   sequence s_held;
      mode_o inside {3'd2, 3'd3, 3'd4} && !wake_irq_i && !reset_cancel_i;
   endsequence
   AST_WFI_SLEEP:
   assert property (s_wfi_go ##0 !sby_reg |=> mode_o == 3'd1)
      else $error("wait request missed sleep");
   AST_WFI_STANDBY:
   assert property (s_wfi_go ##0 (sby_reg && !dps_reg) |=> mode_o == 3'd2)
      else $error("wait request missed standby");
   AST_WFI_DEEP:
   assert property (s_wfi_go ##0 (sby_reg && dps_reg) |=> mode_o == 3'd4)
      else $error("wait request missed deep standby");
   AST_IDLE_NORMAL:
   assert property (mode_o == 3'd0 && !wfi_i |=> mode_o == 3'd0)
      else $error("left normal without wait request");
   AST_SNOOZE_SOURCE:
   assert property (mode_o == 3'd3 && $past(mode_o) != 3'd3
      |-> $past(mode_o) == 3'd2) else $error("snooze not from standby");
   AST_SLEEP_WAKE:
   assert property (mode_o == 3'd1 && any_irq_i && !reset_cancel_i
      |=> mode_o == 3'd0 && resume_o && !reset_req_o)
      else $error("sleep not left by interrupt");
   AST_STANDBY_HOLD:
   assert property (s_held ##0 !snooze_req_i |=> $stable(mode_o))
      else $error("standby left without wake source");
   AST_DEEP_WAKE:
   assert property (mode_o == 3'd4 && wake_irq_i && !reset_cancel_i
      |=> mode_o == 3'd0 && reset_req_o && !resume_o)
      else $error("deep wake did not request reset");
   AST_RESET_CANCEL:
   assert property (mode_o != 3'd0 && reset_cancel_i
      |=> mode_o == 3'd0 && reset_req_o && !resume_o)
      else $error("reset cancel missed reset state");
   AST_OSC_MASK:
   assert property (osc_allow_o == osc_of($past(opc_mode_o)))
      else $error("oscillator mask wrong for mode");
   AST_WB_ANSWER:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      |=> wb_ack_o ^ wb_err_o) else $error("bus request unanswered");
endmodule
bind lpmc_top lpmc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .wfi_i(wfi_i), .any_irq_i(any_irq_i),
   .wake_irq_i(wake_irq_i), .snooze_req_i(snooze_req_i),
   .reset_cancel_i(reset_cancel_i), .mode_o(mode_o), .resume_o(resume_o),
   .reset_req_o(reset_req_o), .opc_mode_o(opc_mode_o),
   .osc_allow_o(osc_allow_o));

// file: bench/lpmc_core_model.sv
`timescale 1ns/1ps
// core plus wake and reset sources; every event is one cycle long so the
// bench knows exactly which edge the block samples it on
module lpmc_core_model (
   input wire logic clk_i,     // clock
   output logic wfi_o,         // wait request
   output logic any_irq_o,     // interrupt
   output logic wake_irq_o,    // wake source
   output logic snooze_req_o,  // snooze trigger
   output logic reset_cancel_o // reset source
);
   initial {wfi_o, any_irq_o, wake_irq_o, snooze_req_o, reset_cancel_o} = 5'h0;
   // drive the chosen events for one cycle, then idle low
   task automatic fire(input logic [4:0] ev);
      @(posedge clk_i);
      {wfi_o, any_irq_o, wake_irq_o, snooze_req_o, reset_cancel_o} <= ev;
      @(posedge clk_i);
      {wfi_o, any_irq_o, wake_irq_o, snooze_req_o, reset_cancel_o} <= 5'h0;
   endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o, clk_div_o, module_stop_o, secure_attr_o, q;
   logic wb_ack_o, wb_err_o, resume_o, reset_req_o, bus_clk_high_o;
   logic wfi_i, any_irq_i, wake_irq_i, snooze_req_i, reset_cancel_i;
   logic [2:0] mode_o;
   logic [1:0] opc_mode_o;
   logic [6:0] osc_allow_o;
   int fail_count = 0;
   int comparisons = 0;
   localparam logic [4:0] WAIT_FOR_INTERRUPT_INSTRUCTION = 5'h10, IRQ = 5'h08, WAKE = 5'h04;
   localparam logic [4:0] SNZ = 5'h02, RST = 5'h01;
   logic [1:0] opc_tab [4] = '{2'h0, 2'h1, 2'h1, 2'h3};
   logic [6:0] osc_tab [4] = '{lpmc_pkg::OSC_ALL, lpmc_pkg::OSC_NO_PLL,
      lpmc_pkg::OSC_NO_PLL, lpmc_pkg::OSC_SUBOSC};

   always #20 clk_i = ~clk_i;

   lpmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wfi_i(wfi_i),
      .any_irq_i(any_irq_i), .wake_irq_i(wake_irq_i),
      .snooze_req_i(snooze_req_i), .reset_cancel_i(reset_cancel_i),
      .mode_o(mode_o), .resume_o(resume_o), .reset_req_o(reset_req_o),
      .opc_mode_o(opc_mode_o), .osc_allow_o(osc_allow_o),
      .clk_div_o(clk_div_o), .bus_clk_high_o(bus_clk_high_o),
      .module_stop_o(module_stop_o), .secure_attr_o(secure_attr_o));
   lpmc_core_model core (.clk_i(clk_i), .wfi_o(wfi_i), .any_irq_o(any_irq_i),
      .wake_irq_o(wake_irq_i), .snooze_req_o(snooze_req_i),
      .reset_cancel_o(reset_cancel_i));

   task automatic chk(input logic [31:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one classic cycle; answer and read data are taken at the rising edge
   // that samples ack high, and the request is released at that same edge
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic e, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(wb_ack_o | wb_err_o) && n < 20);
      r = wb_dat_o;
      chk({wb_ack_o, wb_err_o}, {~e, e}, "bus answer");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 1'b0, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
      wb(1'b0, a, 32'h0000_0000, 1'b0, q);
      chk(q, e, s);
   endtask
   // one event, then mode and the {resume, reset} pulses one cycle later
   task automatic ev(input logic [4:0] e, input logic [2:0] m,
      input logic [1:0] p);
      core.fire(e);
      #1;
      chk(m === mode_o, 1'b1, "mode");
      chk({resume_o, reset_req_o}, p, "exit pulse");
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(lpmc_pkg::MODULE_STOP_OFS, lpmc_pkg::MODULE_STOP_RST, "stop");
      wb(1'b0, 8'h40, 32'h0000_0000, 1'b1, q);
      wr(lpmc_pkg::MODULE_STOP_OFS, 32'hFFFF_FF00);
      wr(lpmc_pkg::MODULE_STOP_OFS, 32'h0000_0005);
      chk(module_stop_o, 32'h0000_0005, "stop bits");
      wr(lpmc_pkg::CLOCK_DIVIDER_OFS, 32'h0765_4321);
      chk(clk_div_o, 32'h0765_4321, "dividers");
      wr(lpmc_pkg::BUS_CLOCK_PIN_OFS, 32'h0000_0001);
      chk(bus_clk_high_o, 1'b1, "bus pin");
      wr(lpmc_pkg::SECURITY_ATTR_OFS, 32'hA5A5_5A5A);
      rd(lpmc_pkg::SECURITY_ATTR_OFS, 32'hA5A5_5A5A, "attr");
      $display("register test done");
      // code 10 is refused, so the low-speed entry must survive it
      for (int i = 0; i < 4; i++) begin
         wr(lpmc_pkg::OPERATING_POWER_CONTROL_OFS, 32'(i));
         repeat (2) @(posedge clk_i);
         #1;
         chk(opc_mode_o, opc_tab[i], "opc");
         chk(osc_allow_o, osc_tab[i], "osc");
      end
      // status shows mode 0 and the subosc mask in bits 10:4
      rd(lpmc_pkg::MODE_STATUS_OFS, 32'h0000_0680, "status");
      $display("power mode test done");
      wr(lpmc_pkg::STANDBY_CONTROL_OFS, 32'h0000_0000);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd1, 2'b00);
      ev(IRQ, 3'd0, 2'b10);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd1, 2'b00);
      ev(RST | IRQ, 3'd0, 2'b01);
      wr(lpmc_pkg::STANDBY_CONTROL_OFS, 32'h0000_8000);
      ev(SNZ | IRQ, 3'd0, 2'b00);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd2, 2'b00);
      ev(SNZ | IRQ, 3'd2, 2'b00);
      ev(WAKE, 3'd0, 2'b10);
      wr(lpmc_pkg::SNOOZE_CONTROL_OFS, 32'h0000_0080);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd2, 2'b00);
      ev(SNZ, 3'd3, 2'b00);
      ev(IRQ | WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd3, 2'b00);
      ev(WAKE, 3'd0, 2'b10);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd2, 2'b00);
      ev(RST | WAKE, 3'd0, 2'b01);
      $display("standby test done");
      wr(lpmc_pkg::DEEP_STANDBY_CONTROL_OFS, 32'h0000_0080);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd4, 2'b00);
      ev(SNZ | IRQ, 3'd4, 2'b00);
      ev(WAKE, 3'd0, 2'b01);
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd4, 2'b00);
      ev(RST, 3'd0, 2'b01);
      $display("deep standby test done");
      // reset while parked in deep standby must return mode, power mode, oscillator mask and module stops to reset
      ev(WAIT_FOR_INTERRUPT_INSTRUCTION, 3'd4, 2'b00);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk(mode_o, 3'd0, "mode after reset");
      chk(opc_mode_o, 2'h0, "opc after reset");
      chk(osc_allow_o, lpmc_pkg::OSC_ALL, "osc after reset");
      rd(lpmc_pkg::MODULE_STOP_OFS, lpmc_pkg::MODULE_STOP_RST, "stop");
      $display("reset test done");
      stop_test;
   end
   // the tests need well under a thousand cycles; this is ample margin
   initial begin
      #200000;
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test;
   end
endmodule
